// ### design/speed_encoder_fault_monitor_params.svh
// Constants for the speed encoder fault monitor
// Function
// (R01) Mode zero disables all encoder supervision
// (R02) Mode two faults when enabled check times out
// (R03) Supervise speed signal, channel signal, division marks
// (R04) Arm only with drive release and start
// (R05) Condition must hold uninterrupted for full timeout
// (R06) Zero timeout disables only that check
// (R07) Timeouts 0 to 65000 ms, default 1000
// (R08) Dead signal: speed zero with nonzero reference
// (R09) Check x4 channel edge order for illegal steps
// (R10) Channel fault after faulty signal for timeout
// (R11) Direction fault when reference and speed signs differ
// (R12) Quarter turn in reference direction restarts direction check
// (R13) Timeout while released commands output stage shutdown
// (R14) Each fault reported with its own code
// (R15) Own ms counter per check from 1 ms tick
`ifndef SPEED_ENCODER_FAULT_MONITOR_PARAMS_SVH
`define SPEED_ENCODER_FAULT_MONITOR_PARAMS_SVH
`define CLK_PERIOD_PS 5000
`define TICK_TIME_PS 1000000000
`define TICK_CYCLES (`TICK_TIME_PS / `CLK_PERIOD_PS)
`define ADDR_MODE 4'h0
`define ADDR_TO_DEAD 4'h1
`define ADDR_TO_CHAN 4'h2
`define ADDR_TO_DIR 4'h3
`define ADDR_STATUS 4'h4
`define ADDR_MASK 4'h5
`define ADDR_FAULT_CODE 4'h6
`define ADDR_QUARTER 4'h7
`define TIMEOUT_MAX 16'hFDE8
`define TIMEOUT_RESET 16'h03E8
`define QUARTER_RESET 16'h0100
`define MODE_OFF 2'h0
`define MODE_ERROR 2'h2
`define CODE_NONE 16'h0000
`define CODE_DEAD 16'h0001
`define CODE_CHAN 16'h0002
`define CODE_DIR 16'h0003
`define STAT_DEAD 0
`define STAT_CHAN 1
`define STAT_DIR 2
`endif

// ### design/speed_encoder_fault_monitor_pkg.sv
// Types for the speed encoder fault monitor
package speed_encoder_fault_monitor_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic phaseA;
		logic phaseB;
	} enc_pins_t;
	typedef enum logic [1:0] {ARM_IDLE, ARM_RUN, ARM_TRIPPED} arm_state_t;
endpackage : speed_encoder_fault_monitor_pkg

// ### design/fault_timer.sv
// Millisecond persistence timer for one supervision check
`timescale 1ns/100ps
`include "speed_encoder_fault_monitor_params.svh"
module fault_timer (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Control
	input wire logic armed,
	input wire logic msTick,
	input wire logic condition,
	input wire logic restart,
	input wire logic [15:0] timeout,
	// Result
	output logic expired
);
	logic [15:0] msCount;

	// Condition lapse or restart clears the count; zero timeout disables
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			msCount <= 16'h0000;
		end else if (!armed || !condition || restart || timeout == 16'h0000) begin // R05 R06
			msCount <= 16'h0000;
		end else if (msTick && msCount != 16'hFFFF) begin // R15
			msCount <= msCount + 16'h0001;
		end
	end

	// Gated by the live condition so a lapse in the expiry cycle never trips
	assign expired = armed && condition && timeout != 16'h0000 && msCount >= timeout; // R05 R06

	disabled_quiet_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(timeout == 16'h0000) |-> !expired) else $error("expired with zero timeout"); // R06
	lapse_clears_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(armed && !condition) |=> (msCount == 16'h0000)) else $error("count kept on lapse"); // R05
endmodule : fault_timer

// ### design/speed_encoder_fault_monitor.sv
// Quadrature speed encoder fault monitor with register port
`timescale 1ns/100ps
`include "speed_encoder_fault_monitor_params.svh"
module speed_encoder_fault_monitor
	import speed_encoder_fault_monitor_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Register port
	input wire reg_req_t regReq,
	output logic [15:0] readData,
	// Drive control
	input wire logic driveRelease,
	input wire logic startCmd,
	input wire logic signed [15:0] speedRef,
	input wire logic signed [15:0] speedActual,
	// Encoder
	input wire enc_pins_t encPins,
	input wire logic divisionMark,
	// Results
	output logic faultShutdown,
	output logic [15:0] faultCode,
	output logic irq
);
	logic [1:0] mode;
	logic [15:0] toDead;
	logic [15:0] toChan;
	logic [15:0] toDir;
	logic [15:0] quarterCounts;
	logic [2:0] status;
	logic [2:0] mask;
	logic [31:0] tickCount;
	logic msTick;
	enc_pins_t prevPins;
	logic channelBad;
	logic signed [17:0] dirTravel;
	logic quarterDone;
	logic armed;
	logic deadCond;
	logic dirCond;
	logic expDead;
	logic expChan;
	logic expDir;
	logic [2:0] events;
	arm_state_t armState;
	arm_state_t next_armState;

	// Binary position of a Gray AB pair, so a legal x4 step changes it by one
	function automatic logic [1:0] quadPos(input enc_pins_t p);
		quadPos = {p.phaseA, p.phaseA ^ p.phaseB};
	endfunction : quadPos

	// Clamp a write to the allowed timeout range
	function automatic logic [15:0] clampTimeout(input logic [15:0] v);
		clampTimeout = (v > `TIMEOUT_MAX) ? `TIMEOUT_MAX : v;
	endfunction : clampTimeout

	// Configuration registers
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode <= `MODE_ERROR;
			toDead <= `TIMEOUT_RESET; // R07
			toChan <= `TIMEOUT_RESET; // R07
			toDir <= `TIMEOUT_RESET; // R07
			mask <= 3'h0;
			quarterCounts <= `QUARTER_RESET;
		end else if (regReq.wr) begin
			unique case (regReq.addr)
				`ADDR_MODE: mode <= regReq.wdata[1:0];
				`ADDR_TO_DEAD: toDead <= clampTimeout(regReq.wdata); // R07
				`ADDR_TO_CHAN: toChan <= clampTimeout(regReq.wdata); // R07
				`ADDR_TO_DIR: toDir <= clampTimeout(regReq.wdata); // R07
				`ADDR_MASK: mask <= regReq.wdata[2:0];
				`ADDR_QUARTER: quarterCounts <= regReq.wdata;
				default: ;
			endcase
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			readData <= 16'h0000;
		end else if (regReq.rd) begin
			unique case (regReq.addr)
				`ADDR_MODE: readData <= {14'h0000, mode};
				`ADDR_TO_DEAD: readData <= toDead;
				`ADDR_TO_CHAN: readData <= toChan;
				`ADDR_TO_DIR: readData <= toDir;
				`ADDR_STATUS: readData <= {13'h0000, status};
				`ADDR_MASK: readData <= {13'h0000, mask};
				`ADDR_FAULT_CODE: readData <= faultCode; // R14
				`ADDR_QUARTER: readData <= quarterCounts;
				default: readData <= 16'h0000;
			endcase
		end else begin
			readData <= 16'h0000;
		end
	end

	// One millisecond time base
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tickCount <= 32'h00000000;
			msTick <= 1'b0;
		end else if (tickCount >= 32'(TICK_CYCLES - 1)) begin
			tickCount <= 32'h00000000;
			msTick <= 1'b1; // R15
		end else begin
			tickCount <= tickCount + 32'h00000001;
			msTick <= 1'b0;
		end
	end

	// Supervision armed by release, start and mode two while in the run state
	assign armed = driveRelease && startCmd && mode == `MODE_ERROR && armState == ARM_RUN; // R01 R02 R04

	always_comb begin
		next_armState = armState;
		unique case (armState)
			ARM_IDLE: if (driveRelease && startCmd && mode != `MODE_OFF) next_armState = ARM_RUN; // R04
			ARM_RUN: begin
				if (!driveRelease || !startCmd || mode == `MODE_OFF) begin // R01 R04
					next_armState = ARM_IDLE;
				end else if (expDead || expChan || expDir) begin
					next_armState = ARM_TRIPPED; // R13
				end
			end
			ARM_TRIPPED: if (!driveRelease) next_armState = ARM_IDLE;
			default: next_armState = ARM_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			armState <= ARM_IDLE;
		end else begin
			armState <= next_armState;
		end
	end

	// Encoder edge order; a two-step jump is illegal under x4 evaluation
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			prevPins <= '0;
			channelBad <= 1'b0;
		end else begin
			prevPins <= encPins;
			if (quadPos(encPins) == quadPos(prevPins) + 2'h2) begin
				channelBad <= 1'b1; // R03 R09
			end else if (quadPos(encPins) != quadPos(prevPins) || divisionMark) begin
				channelBad <= 1'b0; // R03
			end
		end
	end

	// Travel in the reference direction; a quarter turn restarts the check
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dirTravel <= 18'sh00000;
		end else if (!dirCond || quarterDone) begin
			dirTravel <= 18'sh00000; // R12
		end else if (quadPos(encPins) == quadPos(prevPins) + 2'h1) begin
			dirTravel <= speedRef[15] ? dirTravel - 18'sh00001 : dirTravel + 18'sh00001;
		end else if (quadPos(encPins) == quadPos(prevPins) - 2'h1) begin
			dirTravel <= speedRef[15] ? dirTravel + 18'sh00001 : dirTravel - 18'sh00001;
		end
	end

	// Stored count is a fourth of a turn in x4 edges
	assign quarterDone = dirTravel >= $signed({2'b00, quarterCounts}); // R12

	assign deadCond = speedActual == 16'sh0000 && speedRef != 16'sh0000; // R03 R08
	assign dirCond = speedRef != 16'sh0000 && speedActual != 16'sh0000
		&& (speedRef[15] != speedActual[15]); // R11

	fault_timer deadTimer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.armed(armed),
		.msTick(msTick),
		.condition(deadCond),
		.restart(1'b0),
		.timeout(toDead),
		.expired(expDead)
	); // R08

	fault_timer chanTimer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.armed(armed),
		.msTick(msTick),
		.condition(channelBad),
		.restart(1'b0),
		.timeout(toChan),
		.expired(expChan)
	); // R10

	fault_timer dirTimer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.armed(armed),
		.msTick(msTick),
		.condition(dirCond),
		.restart(quarterDone),
		.timeout(toDir),
		.expired(expDir)
	); // R11 R12

	assign events = {expDir, expChan, expDead};

	// Sticky status; a new event wins over a write-one clear
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			status <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (events[i]) begin
					status[i] <= 1'b1;
				end else if (regReq.wr && regReq.addr == `ADDR_STATUS && regReq.wdata[i]) begin
					status[i] <= 1'b0;
				end
			end
		end
	end

	assign irq = |(status & mask);

	// First fault code latched; shutdown holds until release is dropped
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			faultShutdown <= 1'b0;
			faultCode <= `CODE_NONE;
		end else if (armed && (expDead || expChan || expDir)) begin
			faultShutdown <= 1'b1; // R02 R13
			if (faultCode == `CODE_NONE) begin
				faultCode <= expDead ? `CODE_DEAD : expChan ? `CODE_CHAN : `CODE_DIR; // R14
			end
		end else if (!driveRelease) begin
			faultShutdown <= 1'b0;
			faultCode <= `CODE_NONE;
		end
	end

	off_no_fault_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(mode == `MODE_OFF && !faultShutdown) |=> !faultShutdown) else $error("fault in mode off"); // R01
	unarmed_quiet_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(!(driveRelease && startCmd)) |-> !armed) else $error("armed without release"); // R04
	trip_shutdown_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(armed && expChan) |=> faultShutdown) else $error("no shutdown on channel"); // R02
	dead_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(armed && expDead && faultCode == `CODE_NONE) |=> faultCode == `CODE_DEAD)
		else $error("wrong dead code"); // R14
	dead_cause_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		expDead |-> (speedActual == 16'sh0000 && speedRef != 16'sh0000))
		else $error("dead fault without cause"); // R08
	dir_cause_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		expDir |-> (speedRef[15] != speedActual[15])) else $error("direction fault, same sign"); // R11
	chan_cause_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		expChan |-> channelBad) else $error("channel fault without bad signal"); // R10
	timeout_range_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		toDead <= `TIMEOUT_MAX && toChan <= `TIMEOUT_MAX && toDir <= `TIMEOUT_MAX)
		else $error("timeout above range"); // R07
	tick_period_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		msTick |=> !msTick) else $error("tick too long"); // R15
	quarter_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		quarterDone |=> dirTravel == 18'sh00000) else $error("travel not restarted"); // R12
	skip_detect_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(quadPos(encPins) == quadPos(prevPins) + 2'h2) |=> channelBad)
		else $error("skip not flagged"); // R09
endmodule : speed_encoder_fault_monitor

// ### testbench/quad_encoder_model.sv
// Quadrature encoder model standing on the motor shaft
`timescale 1ns/100ps
module quad_encoder_model
	import speed_encoder_fault_monitor_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// Motion requests
	input wire logic stepFwd,
	input wire logic stepSkip,
	// Pins
	output enc_pins_t encPins
);
	logic [1:0] position = 2'h0;
	// A skip jumps two states, so both phases flip at once
	always @(posedge core_clk) begin
		if (stepSkip) begin
			position <= position + 2'h2;
		end else if (stepFwd) begin
			position <= position + 2'h1;
		end
	end
	assign encPins = '{phaseA: position[1], phaseB: position[1] ^ position[0]};
endmodule : quad_encoder_model

// ### testbench/speed_encoder_fault_monitor_test.sv
// Self-checking bench for the speed encoder fault monitor
`timescale 1ns/100ps
`include "speed_encoder_fault_monitor_params.svh"
module speed_encoder_fault_monitor_test
	import speed_encoder_fault_monitor_pkg::*;
;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	reg_req_t regReq = '0;
	logic [15:0] readData;
	logic driveRelease = 1'b0;
	logic startCmd = 1'b0;
	logic signed [15:0] speedRef = 16'sh0000;
	logic signed [15:0] speedActual = 16'sh0000;
	enc_pins_t encPins;
	logic divisionMark = 1'b0;
	logic stepFwd = 1'b0;
	logic stepSkip = 1'b0;
	logic faultShutdown;
	logic [15:0] faultCode;
	logic irq;
	logic [15:0] value;
	int mismatches = 0;
	int total_checks = 0;
	always #2.5 core_clk = ~core_clk;
	// Short tick so a millisecond is ten clocks
	speed_encoder_fault_monitor #(.TICK_CYCLES(10)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .regReq(regReq), .readData(readData),
		.driveRelease(driveRelease), .startCmd(startCmd), .speedRef(speedRef),
		.speedActual(speedActual), .encPins(encPins), .divisionMark(divisionMark),
		.faultShutdown(faultShutdown), .faultCode(faultCode), .irq(irq)
	);
	quad_encoder_model encoder (
		.core_clk(core_clk), .stepFwd(stepFwd), .stepSkip(stepSkip), .encPins(encPins)
	);
	task automatic check(input string name, input logic [15:0] expected, input logic [15:0] seen);
		total_checks++;
		if (seen !== expected) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, expected, seen);
		end
	endtask : check
	task automatic regWrite(input logic [3:0] addr, input logic [15:0] data);
		@(posedge core_clk);
		regReq <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		regReq.wr <= 1'b0;
	endtask : regWrite
	task automatic regRead(input logic [3:0] addr, output logic [15:0] data);
		@(posedge core_clk);
		regReq <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		regReq.rd <= 1'b0;
		#1 data = readData;
	endtask : regRead
	task automatic setup(input logic [15:0] dead, chan, dir, mask);
		regWrite(`ADDR_TO_DEAD, dead);
		regWrite(`ADDR_TO_CHAN, chan);
		regWrite(`ADDR_TO_DIR, dir);
		regWrite(`ADDR_MASK, mask);
	endtask : setup
	task automatic arm(input logic start);
		@(posedge core_clk);
		driveRelease <= 1'b1;
		startCmd <= start;
	endtask : arm
	task automatic holdMs(input int ms);
		repeat (ms * 10) @(posedge core_clk);
		#1;
	endtask : holdMs
	// Bounded wait, then the code, status and clearing of one fault
	task automatic expectFault(input logic [15:0] code, input logic [15:0] bits);
		for (int i = 0; i < 100 && faultShutdown !== 1'b1; i++) @(posedge core_clk);
		#1 check("faultShutdown", 16'h0001, {15'h0, faultShutdown});
		check("faultCode", code, faultCode);
		regRead(`ADDR_FAULT_CODE, value);
		check("faultCodeReg", code, value);
		regRead(`ADDR_STATUS, value);
		check("status", bits, value);
		@(posedge core_clk);
		speedActual <= speedRef;
		stepSkip <= 1'b0;
		// Index mark clears a bad channel left over from a skip run
		divisionMark <= 1'b1;
		regWrite(`ADDR_STATUS, bits);
		regRead(`ADDR_STATUS, value);
		check("statusCleared", 16'h0000, value);
		@(posedge core_clk);
		divisionMark <= 1'b0;
		driveRelease <= 1'b0;
		startCmd <= 1'b0;
		holdMs(1);
		check("shutdownCleared", 16'h0000, {15'h0, faultShutdown});
	endtask : expectFault
	task automatic testDefaults();
		regRead(`ADDR_MODE, value);
		check("mode", {14'h0, `MODE_ERROR}, value);
		for (int a = 1; a <= 3; a++) begin
			regRead(a[3:0], value);
			check("timeoutDefault", `TIMEOUT_RESET, value);
		end
		regRead(4'hF, value);
		check("unmapped", 16'h0000, value);
		regWrite(`ADDR_TO_DIR, 16'hFFFF);
		regRead(`ADDR_TO_DIR, value);
		check("timeoutClamp", `TIMEOUT_MAX, value);
	endtask : testDefaults
	task automatic testDead();
		setup(16'h0003, 16'h0000, 16'h0000, 16'h0001);
		speedRef <= 16'sh0064;
		speedActual <= 16'sh0000;
		arm(1'b1);
		holdMs(2);
		@(posedge core_clk);
		speedActual <= 16'sh0005;
		@(posedge core_clk);
		speedActual <= 16'sh0000;
		holdMs(2);
		check("deadEarly", 16'h0000, {15'h0, faultShutdown});
		check("irqIdle", 16'h0000, {15'h0, irq});
		holdMs(2);
		#1 check("irqSet", 16'h0001, {15'h0, irq});
		expectFault(`CODE_DEAD, 16'h0001);
		check("irqCleared", 16'h0000, {15'h0, irq});
	endtask : testDead
	task automatic testChan();
		setup(16'h0000, 16'h0004, 16'h0000, 16'h0000);
		speedActual <= speedRef;
		arm(1'b1);
		stepSkip <= 1'b1;
		holdMs(2);
		@(posedge core_clk);
		stepSkip <= 1'b0;
		stepFwd <= 1'b1;
		@(posedge core_clk);
		stepFwd <= 1'b0;
		stepSkip <= 1'b1;
		holdMs(2);
		check("chanEarly", 16'h0000, {15'h0, faultShutdown});
		expectFault(`CODE_CHAN, 16'h0002);
	endtask : testChan
	task automatic testDir();
		setup(16'h0000, 16'h0000, 16'h0003, 16'h0000);
		speedActual <= -16'sh0064;
		arm(1'b1);
		holdMs(4);
		check("irqMasked", 16'h0000, {15'h0, irq});
		expectFault(`CODE_DIR, 16'h0004);
	endtask : testDir
	// Steady forward travel keeps restarting the direction check
	task automatic testQuarter();
		regRead(`ADDR_QUARTER, value);
		check("quarterDefault", `QUARTER_RESET, value);
		regWrite(`ADDR_QUARTER, 16'h0004);
		setup(16'h0000, 16'h0000, 16'h0003, 16'h0000);
		speedActual <= -16'sh0064;
		arm(1'b1);
		stepFwd <= 1'b1;
		holdMs(6);
		check("quarterRestart", 16'h0000, {15'h0, faultShutdown});
		@(posedge core_clk);
		stepFwd <= 1'b0;
		expectFault(`CODE_DIR, 16'h0004);
	endtask : testQuarter
	task automatic testOff();
		setup(16'h0003, 16'h0003, 16'h0003, 16'h0007);
		regWrite(`ADDR_MODE, 16'h0000);
		speedActual <= 16'sh0000;
		arm(1'b1);
		holdMs(6);
		check("modeOff", 16'h0000, {15'h0, faultShutdown});
		regWrite(`ADDR_MODE, 16'h0002);
		arm(1'b0);
		holdMs(6);
		check("noStart", 16'h0000, {15'h0, faultShutdown});
		regWrite(`ADDR_TO_DEAD, 16'h0000);
		arm(1'b1);
		holdMs(6);
		check("zeroTimeout", 16'h0000, {15'h0, faultShutdown});
		check("noCode", `CODE_NONE, faultCode);
	endtask : testOff
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results
	initial begin
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		testDefaults();
		testDead();
		testChan();
		testDir();
		testQuarter();
		testOff();
		results();
	end
	// Whole run is under a thousand clocks; this limit of 20000 clocks leaves ample margin
	initial begin
		#100000;
		mismatches++;
		results();
	end
endmodule : speed_encoder_fault_monitor_test
